// >>> hdl/afr_pkg.sv
// package of register offsets, reset values and sizes for the alarm flag registers
package afr_pkg;
    localparam int MAX_CH = 8;
    localparam int CH_PER_REG = 4;
    localparam int ADDR_W = 8;
    typedef logic [ADDR_W-1:0] afr_addr_t;
    typedef logic [7:0] afr_byte_t;
    typedef logic [MAX_CH-1:0] afr_chvec_t;
    localparam afr_addr_t ADDR_OVERVIEW = 8'h10;
    localparam afr_addr_t ADDR_TRIP_LO = 8'h11;
    localparam afr_addr_t ADDR_ACT_LO = 8'h12;
    localparam afr_addr_t ADDR_TRIP_HI = 8'h13;
    localparam afr_addr_t ADDR_ACT_HI = 8'h14;
    localparam afr_byte_t FLAGS_RST = 8'h00;
    localparam afr_byte_t ABSENT_READ = 8'hFF;
    localparam afr_byte_t UNMAPPED_READ = 8'h00;
    localparam afr_chvec_t CHVEC_RST = 8'h00;
    localparam afr_chvec_t CHVEC_ONES = 8'hFF;
endpackage

// >>> hdl/afr_flag_if.sv
// interface between the register front end and the flag bank
`timescale 1ns/10ps
`default_nettype none
interface afr_flag_if;
    import afr_pkg::*;
    logic sample;
    afr_chvec_t hi_meas;
    afr_chvec_t lo_meas;
    afr_chvec_t clr;
    afr_chvec_t hi_act;
    afr_chvec_t lo_act;
    afr_chvec_t hi_trip;
    afr_chvec_t lo_trip;
    modport bank (
        input sample,
        input hi_meas,
        input lo_meas,
        input clr,
        output hi_act,
        output lo_act,
        output hi_trip,
        output lo_trip
    );
    modport ctrl (
        output sample,
        output hi_meas,
        output lo_meas,
        output clr,
        input hi_act,
        input lo_act,
        input hi_trip,
        input lo_trip
    );
endinterface
`default_nettype wire

// >>> hdl/afr_flag_bank.sv
// per channel live and latched alarm flags, high and low threshold
`timescale 1ns/10ps
`default_nettype none
module afr_flag_bank (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // flag traffic
    afr_flag_if.bank f
);
    import afr_pkg::*;

    afr_chvec_t act_hi_q, act_hi_d, act_lo_q, act_lo_d;
    afr_chvec_t trip_hi_q, trip_hi_d, trip_lo_q, trip_lo_d;

    for (genvar i = 0; i < MAX_CH; i++) begin : g_ch
        always_comb begin
            // live flag follows each new comparison result, high and low alike
            act_hi_d[i] = f.sample ? f.hi_meas[i] : act_hi_q[i]; // R2
            act_lo_d[i] = f.sample ? f.lo_meas[i] : act_lo_q[i]; // R2
            // a new hit in the clearing cycle survives the read
            trip_hi_d[i] = (f.sample & f.hi_meas[i]) | (trip_hi_q[i] & ~f.clr[i]); // R3
            trip_lo_d[i] = (f.sample & f.lo_meas[i]) | (trip_lo_q[i] & ~f.clr[i]); // R3
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            act_hi_q <= CHVEC_RST; // R7
            act_lo_q <= CHVEC_RST;
            trip_hi_q <= CHVEC_RST;
            trip_lo_q <= CHVEC_RST;
        end else begin
            act_hi_q <= act_hi_d;
            act_lo_q <= act_lo_d;
            trip_hi_q <= trip_hi_d;
            trip_lo_q <= trip_lo_d;
        end
    end

    assign f.hi_act = act_hi_q; // R1
    assign f.lo_act = act_lo_q;
    assign f.hi_trip = trip_hi_q;
    assign f.lo_trip = trip_lo_q;
endmodule
`default_nettype wire

// >>> hdl/afr_alarm_regs.sv
// alarm flag register bank: live and latched flags, overview, read port
//
// Overview of operation
// (R1) Every channel has a high and a low alarm, each with a live flag and a latched flag.
// (R2) A live flag is 1 while the channel's data lie beyond its limit and drops to 0 once they do not.
// (R3) A latched flag sets with its live flag, stays set after the condition ends, and clears when read.
// (R4) The overview register at 10h holds per channel the OR of its high and low latched flags, channel 7 in bit 7.
// (R5) Register 11h holds latched flags of channels 0-3 as low/high pairs, channel 0 low in bit 7 to channel 3 high in bit 0.
// (R6) Register 12h holds live flags of channels 0-3 in the same bit order as 11h.
// (R7) Each flag reads 1 for an alarm, 0 for none, and all flags are 0 after reset.
// (R8) On the four channel build, channels 4-7 ignore writes and read as all ones.
// (R9) The host reads these registers after the alarm pin signals an event.
// (R10) The flag registers are read only and the channel flags fill addresses 11h to 14h.
// (R11) On the eight channel build, 13h holds latched and 14h live flags of channels 4-7, low/high pairs.
// (R12) Reading a latched register clears only its own flags, and a still present condition sets them again.
`timescale 1ns/10ps
`default_nettype none
module afr_alarm_regs #(
    parameter int NUM_CH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // comparison results, one strobe per finished conversion
    input wire logic conv_valid,
    input wire afr_pkg::afr_chvec_t cond_high,
    input wire afr_pkg::afr_chvec_t cond_low,
    // register read port
    input wire logic reg_rd,
    input wire afr_pkg::afr_addr_t reg_addr,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_hit,
    // alarm indication pin
    output logic alarm_out
);
    import afr_pkg::*;

    afr_flag_if f();

    afr_flag_bank u_bank (
        .clock(clock),
        .nrst(nrst),
        .f(f)
    );

    afr_chvec_t present;
    afr_chvec_t meas_hi, meas_lo, clr_vec, ovw;
    afr_byte_t rdata_q, rdata_d;
    logic rvalid_q, rvalid_d, hit_q, hit_d, alarm_q, alarm_d;
    logic rd_trip_lo, rd_trip_hi;

    // packs four channels as low/high pairs, first channel in the top bits
    function automatic afr_byte_t pack4(input int base, input afr_chvec_t lo, input afr_chvec_t hi,
                                        input afr_chvec_t pres);
        afr_byte_t b;
        b = FLAGS_RST;
        for (int k = 0; k < CH_PER_REG; k++) begin
            b[7-2*k] = pres[base+k] ? lo[base+k] : 1'b1; // R8
            b[6-2*k] = pres[base+k] ? hi[base+k] : 1'b1; // R8
        end
        return b;
    endfunction

    for (genvar i = 0; i < MAX_CH; i++) begin : g_pres
        assign present[i] = (i < NUM_CH);
    end

    always_comb begin
        // absent channels never see a condition, so their flags stay at reset
        meas_hi = cond_high & present; // R8
        meas_lo = cond_low & present;
        rd_trip_lo = reg_rd && (reg_addr == ADDR_TRIP_LO);
        rd_trip_hi = reg_rd && (reg_addr == ADDR_TRIP_HI) && (NUM_CH > CH_PER_REG);
        // each latched register clears only its own four channels
        clr_vec = {{4{rd_trip_hi}}, {4{rd_trip_lo}}}; // R12
        for (int c = 0; c < MAX_CH; c++) begin
            ovw[c] = present[c] ? (f.hi_trip[c] | f.lo_trip[c]) : 1'b1; // R4
        end
    end

    assign f.sample = conv_valid;
    assign f.hi_meas = meas_hi;
    assign f.lo_meas = meas_lo;
    assign f.clr = clr_vec;

    always_comb begin
        rdata_d = rdata_q;
        hit_d = 1'b0;
        rvalid_d = reg_rd;
        alarm_d = |(f.hi_trip | f.lo_trip);
        if (reg_rd) begin
            hit_d = 1'b1;
            case (reg_addr)
                ADDR_OVERVIEW: rdata_d = ovw; // R4
                ADDR_TRIP_LO: rdata_d = pack4(0, f.lo_trip, f.hi_trip, present); // R5
                ADDR_ACT_LO: rdata_d = pack4(0, f.lo_act, f.hi_act, present); // R6
                ADDR_TRIP_HI: rdata_d = pack4(CH_PER_REG, f.lo_trip, f.hi_trip, present); // R11
                ADDR_ACT_HI: rdata_d = pack4(CH_PER_REG, f.lo_act, f.hi_act, present); // R11
                default: begin
                    // other addresses belong to registers outside this bank
                    rdata_d = UNMAPPED_READ;
                    hit_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= FLAGS_RST;
            rvalid_q <= 1'b0;
            hit_q <= 1'b0;
            alarm_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            hit_q <= hit_d;
            alarm_q <= alarm_d;
        end
    end

    // no write path exists: the bank is read only and writes cannot reach a flag
    assign reg_rdata = rdata_q; // R10
    assign reg_rvalid = rvalid_q;
    assign reg_hit = hit_q;
    // host is expected to read the flags on this level
    assign alarm_out = alarm_q; // R9

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence seq_rd_trip_lo;
        reg_rd && (reg_addr == ADDR_TRIP_LO) && !conv_valid;
    endsequence

    sequence seq_quiet2;
        !conv_valid && !reg_rd ##1 !conv_valid && !reg_rd;
    endsequence

    a_live_follow_hi: assert property (conv_valid |=> f.hi_act == $past(meas_hi)) // R2
        else $error("live high flags do not match the last comparison");

    a_live_follow_lo: assert property (conv_valid |=> f.lo_act == $past(meas_lo)) // R2
        else $error("live low flags do not match the last comparison");

    a_trip_sets: assert property (conv_valid |=> ((f.hi_trip & $past(meas_hi)) == $past(meas_hi))) // R3
        else $error("latched high flag missed a hit");

    a_trip_holds: assert property (seq_quiet2 |-> $stable(f.hi_trip) && $stable(f.lo_trip)) // R3
        else $error("latched flags changed with no sample and no read");

    a_trip_clear_lo: assert property (seq_rd_trip_lo |=> (f.hi_trip[3:0] == 4'h0) && (f.lo_trip[3:0] == 4'h0)) // R12
        else $error("read of 11h did not clear channels 0-3");

    a_clear_scope: assert property (seq_rd_trip_lo |=> f.hi_trip[7:4] == $past(f.hi_trip[7:4])) // R12
        else $error("read of 11h touched channels 4-7");

    a_set_wins: assert property (reg_rd && reg_addr == ADDR_TRIP_LO && conv_valid && meas_lo[0]
                                 |=> f.lo_trip[0]) // R12
        else $error("hit lost in the clearing cycle");

    a_overview_or: assert property (reg_rd && reg_addr == ADDR_OVERVIEW |=> reg_rdata == $past(ovw)) // R4
        else $error("overview read does not show latched OR");

    a_trip_lo_order: assert property (reg_rd && reg_addr == ADDR_TRIP_LO
                                      |=> reg_rdata[7:6] == {$past(f.lo_trip[0]), $past(f.hi_trip[0])}) // R5
        else $error("channel 0 latched pair misplaced in 11h");

    a_act_lo_order: assert property (reg_rd && reg_addr == ADDR_ACT_LO
                                     |=> reg_rdata[1:0] == {$past(f.lo_act[3]), $past(f.hi_act[3])}) // R6
        else $error("channel 3 live pair misplaced in 12h");

    a_absent_ones: assert property ((NUM_CH <= CH_PER_REG) && reg_rd
                                    && (reg_addr == ADDR_TRIP_HI || reg_addr == ADDR_ACT_HI)
                                    |=> reg_rdata == ABSENT_READ) // R8
        else $error("absent channels did not read as all ones");

    a_absent_quiet: assert property ((NUM_CH <= CH_PER_REG) |-> f.hi_trip[7:4] == 4'h0) // R8
        else $error("absent channel latched an alarm");

    a_read_valid: assert property (reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd))) // R10
        else $error("read answer not one cycle after request");

    a_alarm_pin: assert property (##1 alarm_out == $past(|(f.hi_trip | f.lo_trip))) // R9
        else $error("alarm pin does not reflect latched flags");
endmodule
`default_nettype wire

// >>> tb/afr_host_model.sv
// host side model: register reads shared by both devices, alarm pin watch
`timescale 1ns/10ps
`default_nettype none
module afr_host_model (
    // clock and alarm pin
    input wire logic clock,
    input wire logic alarm,
    // read request
    output var logic reg_rd,
    output var afr_pkg::afr_addr_t reg_addr,
    // answers, eight channel build in the low half
    input wire logic [1:0] rvalid,
    input wire logic [1:0] hit,
    input wire logic [15:0] rdata
);
    import afr_pkg::*;
    initial begin
        reg_rd = 1'b0;
        reg_addr = 8'h00;
    end
    // the valid and hit flags stand one cycle only, so the answer is taken right after the next edge
    task automatic fetch(input afr_addr_t a, output logic [15:0] d, output logic [1:0] v, output logic [1:0] h);
        @(posedge clock);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #1 d = rdata;
        v = rvalid;
        h = hit;
        reg_rd = 1'b0;
        // no longer qualified, so the old address is not left standing
        reg_addr = ~a;
    endtask
    // watches the alarm pin for four cycles and reports whether it was seen high
    task automatic wait_alarm(output logic seen);
        seen = 1'b0;
        repeat (4) begin
            @(posedge clock);
            #1 seen = seen | (alarm === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench: eight and four channel builds against an integer model
`timescale 1ns/10ps
`default_nettype none
module tb;
    import afr_pkg::*;
    logic clock, nrst, conv_valid, reg_rd, seen;
    afr_chvec_t cond_high, cond_low;
    afr_addr_t reg_addr;
    logic [15:0] rdata;
    logic [1:0] rvalid, hit, alarm;
    int mismatches, checks_done, cycles;
    bit [7:0] live_hi [2], live_lo [2], trip_hi [2], trip_lo [2];
    localparam bit [7:0] PRESENT [2] = '{8'hFF, 8'h0F};
    localparam afr_addr_t ADDRS [8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h00, 8'h15, 8'hFF};

    afr_alarm_regs #(.NUM_CH(8)) i_afr_alarm_regs (.clock(clock), .nrst(nrst), .conv_valid(conv_valid),
        .cond_high(cond_high), .cond_low(cond_low), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_rdata(rdata[7:0]), .reg_rvalid(rvalid[0]), .reg_hit(hit[0]), .alarm_out(alarm[0]));
    afr_alarm_regs #(.NUM_CH(4)) i_afr_alarm_regs_four (.clock(clock), .nrst(nrst), .conv_valid(conv_valid),
        .cond_high(cond_high), .cond_low(cond_low), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_rdata(rdata[15:8]), .reg_rvalid(rvalid[1]), .reg_hit(hit[1]), .alarm_out(alarm[1]));
    afr_host_model i_afr_host_model (.clock(clock), .alarm(alarm[0]), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .rvalid(rvalid), .hit(hit), .rdata(rdata));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // a healthy run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask

    function automatic bit [7:0] pack(input bit [7:0] h, input bit [7:0] l, input int base);
        pack = 8'h00;
        for (int i = 0; i < 4; i++) begin
            pack[7-2*i] = l[base+i];
            pack[6-2*i] = h[base+i];
        end
    endfunction
    function automatic bit [7:0] model_rd(input int k, input afr_addr_t a);
        case (a)
            8'h10: model_rd = ((trip_hi[k] | trip_lo[k]) & PRESENT[k]) | ~PRESENT[k];
            8'h11: model_rd = pack(trip_hi[k], trip_lo[k], 0);
            8'h12: model_rd = pack(live_hi[k], live_lo[k], 0);
            8'h13: model_rd = (k == 1) ? 8'hFF : pack(trip_hi[k], trip_lo[k], 4);
            8'h14: model_rd = (k == 1) ? 8'hFF : pack(live_hi[k], live_lo[k], 4);
            default: model_rd = 8'h00;
        endcase
    endfunction

    task automatic rd_check(input afr_addr_t a);
        logic [15:0] d;
        logic [1:0] v, h;
        i_afr_host_model.fetch(a, d, v, h);
        for (int k = 0; k < 2; k++) begin
            cmp_byte(d[8*k +: 8], model_rd(k, a));
            cmp_bit(v[k], 1'b1);
            cmp_bit(h[k], (a >= 8'h10) && (a <= 8'h14));
            if (a == 8'h11) begin
                trip_hi[k][3:0] = 4'h0;
                trip_lo[k][3:0] = 4'h0;
            end
            if (a == 8'h13) begin
                trip_hi[k][7:4] = 4'h0;
                trip_lo[k][7:4] = 4'h0;
            end
        end
        // the pin is registered from the flags, so it shows a clear one edge after the read lands
        @(posedge clock);
        #1;
        for (int k = 0; k < 2; k++) begin
            cmp_bit(alarm[k], |(trip_hi[k] | trip_lo[k]));
        end
    endtask
    task automatic rd_all();
        foreach (ADDRS[i]) rd_check(ADDRS[i]);
    endtask
    task automatic conv(input afr_chvec_t hi, input afr_chvec_t lo);
        @(posedge clock);
        #1 conv_valid = 1'b1;
        cond_high = hi;
        cond_low = lo;
        @(posedge clock);
        #1 conv_valid = 1'b0;
        // noise between strobes must not reach the flags
        cond_high = 8'($urandom);
        cond_low = 8'($urandom);
        for (int k = 0; k < 2; k++) begin
            live_hi[k] = hi & PRESENT[k];
            live_lo[k] = lo & PRESENT[k];
            trip_hi[k] |= live_hi[k];
            trip_lo[k] |= live_lo[k];
        end
    endtask
    task automatic do_reset();
        nrst = 1'b0;
        repeat (4) @(posedge clock);
        #1 nrst = 1'b1;
        for (int k = 0; k < 2; k++) begin
            {live_hi[k], live_lo[k], trip_hi[k], trip_lo[k]} = 32'h0;
        end
    endtask

    initial begin
        nrst = 1'b0;
        conv_valid = 1'b0;
        cond_high = 8'h00;
        cond_low = 8'h00;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        void'($urandom(56820));
        do_reset();
        rd_all();
        conv(8'h81, 8'h42);
        i_afr_host_model.wait_alarm(seen);
        cmp_bit(seen, 1'b1);
        conv(8'h00, 8'h00);
        rd_all();
        conv(8'h01, 8'h00);
        rd_check(8'h11);
        conv(8'h01, 8'h00);
        rd_check(8'h11);
        repeat (40) begin
            conv(8'($urandom), 8'($urandom));
            repeat (3) rd_check(ADDRS[$urandom_range(0, 7)]);
        end
        conv(8'hFF, 8'hFF);
        do_reset();
        rd_all();
        conclude();
    end
endmodule
`default_nettype wire
